// ---- rtl/frs_pkg.sv ----
// Purpose: Shared constants and types of the frequency reference selector.
// Assumes: Frequencies in 0.01 Hz units, rates in 0.01 Hz/s units.
// Notes:   Register addresses are word indices on the plain register port.
package frs_pkg;

   // ***********************************************
   // Widths
   // ***********************************************
   localparam int unsigned DW = 16;
   localparam int unsigned AW = 5;
   localparam int unsigned NTERM = 6;
   localparam int unsigned ADJW = 24;

   // ***********************************************
   // Register addresses
   // ***********************************************
   localparam logic [AW-1:0] ADDR_COMBINE_MODE = 5'h00;
   localparam logic [AW-1:0] ADDR_RESERVED_SLOT_A = 5'h01;
   localparam logic [AW-1:0] ADDR_RESERVED_SLOT_B = 5'h02;
   localparam logic [AW-1:0] ADDR_UPDOWN_CONTROL_WORD = 5'h03;
   localparam logic [AW-1:0] ADDR_UP_RATE = 5'h04;
   localparam logic [AW-1:0] ADDR_DOWN_RATE = 5'h05;
   localparam logic [AW-1:0] ADDR_SET_FREQUENCY_MONITOR = 5'h06;
   localparam logic [AW-1:0] ADDR_RAMP_REFERENCE_MONITOR = 5'h07;
   localparam logic [AW-1:0] ADDR_ADJUSTMENT_VALUE_MONITOR = 5'h08;
   localparam logic [AW-1:0] ADDR_CHANNEL_A_SOURCE_SELECT = 5'h09;
   localparam logic [AW-1:0] ADDR_CHANNEL_B_SOURCE_SELECT = 5'h0a;
   localparam logic [AW-1:0] ADDR_MAX_OUTPUT_FREQUENCY = 5'h0b;
   localparam logic [AW-1:0] ADDR_TERMINAL_FUNCTION_0 = 5'h0c;

   // ***********************************************
   // Reset values and limits
   // ***********************************************
   localparam logic [DW-1:0] RST_COMBINE_MODE = 16'h0000;
   localparam logic [DW-1:0] RST_UPDOWN_CONTROL_WORD = 16'h0000;
   localparam logic [DW-1:0] RST_RATE = 16'h0032;
   localparam logic [DW-1:0] RST_SOURCE_A = 16'h0000;
   localparam logic [DW-1:0] RST_SOURCE_B = 16'h000f;
   localparam logic [DW-1:0] RST_MAX_FREQ = 16'h1388;
   localparam logic [DW-1:0] RST_TERM_FUNC = 16'h0000;
   localparam logic [DW-1:0] RATE_MIN = 16'h0001;
   localparam logic [DW-1:0] RATE_MAX = 16'h1388;
   localparam logic [DW-1:0] MODE_MAX = 16'h0005;
   localparam logic [DW-1:0] MAX_FREQ_LIMIT = 16'h9c40;
   localparam logic [DW-1:0] CTRL_MAX = 16'h0221;

   // Control word digit positions and legal digit maxima
   localparam int unsigned ONES_LSB = 0;
   localparam int unsigned TENS_LSB = 4;
   localparam int unsigned HUND_LSB = 8;
   localparam logic [3:0] ONES_MAX = 4'h1;
   localparam logic [3:0] TENS_MAX = 4'h2;
   localparam logic [3:0] HUND_MAX = 4'h2;

   // ***********************************************
   // Modes and terminal function codes
   // ***********************************************
   typedef enum logic [2:0] {
      FRS_SRC_A, FRS_SRC_B, FRS_SRC_SUM, FRS_SRC_DIFF, FRS_SRC_MAX, FRS_SRC_MIN
   } frs_mode_e;

   localparam logic [DW-1:0] FN_UP = 16'h000a;
   localparam logic [DW-1:0] FN_DOWN = 16'h000b;
   localparam logic [DW-1:0] FN_CLEAR = 16'h000c;
   localparam logic [DW-1:0] FN_SWAP_AB = 16'h000d;
   localparam logic [DW-1:0] FN_COMB_TO_A = 16'h000e;
   localparam logic [DW-1:0] FN_COMB_TO_B = 16'h000f;
   localparam logic [DW-1:0] SRC_KEYPAD = 16'h0000;

   // ***********************************************
   // Timing
   // ***********************************************
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned TICK_PERIOD_NS = 10_000_000;
   localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
   // Adjustment kept in 0.0001 Hz: one 10 ms tick adds rate * 0.0001 Hz
   localparam logic [ADJW-1:0] ADJ_SCALE = 24'h000064;

   // ***********************************************
   // Carriers
   // ***********************************************
   typedef struct packed {
      logic [AW-1:0] addr;
      logic [DW-1:0] wdata;
      logic wr;
      logic rd;
   } frs_req_s;

   typedef struct packed {
      logic [NTERM-1:0] level;
      logic running;
      logic stop_cmd;
      logic multistep_priority;
   } frs_pins_s;

endpackage

// ---- rtl/frs_top.sv ----
// Purpose: Main reference combination, terminal switching and up/down
//          auxiliary adjustment with set, ramp and adjustment monitors.
// Assumes: Pin levels are asynchronous; channel values come from logic on
//          clk_sys.
// Notes:   All state lives in one struct registered by one process.
//
// Overview of operation
// (RL1) Combine mode picks A, B, sum, difference, max, min
// (RL2) Up terminal raises the adjustment while active
// (RL3) Down terminal lowers the adjustment while active
// (RL4) Clear terminal zeroes the adjustment on activation
// (RL5) Swap terminal exchanges channels A and B in modes A and B only
// (RL6) Terminal forces combined setting to channel A in modes other than A and B
// (RL7) Terminal forces combined setting to channel B in modes other than A and B
// (RL8) Ones digit enables or ignores up/down
// (RL9) Tens zero: only with keypad source
// (RL10) Tens one: valid for every source
// (RL11) Tens two: ignored under multi-step priority
// (RL12) Hundreds zero: adjustment kept across stop
// (RL13) Hundreds one: cleared once drive stopped
// (RL14) Hundreds two: cleared on stop command
// (RL15) Up and down rates programmable, default 0.50
// (RL16) Monitors limited to zero..max, zero after reset
// (RL17) Reference is main result plus adjustment
// (RL18) Adjustment stepped per tick, result saturated
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module frs_top
   import frs_pkg::*;
#(
   parameter int unsigned TICK_LEN = TICK_CYCLES,
   parameter logic [15:0] RAMP_STEP = 16'h0064
) (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire frs_pkg::frs_req_s req,
   output logic [frs_pkg::DW-1:0] rdata,
   input wire frs_pkg::frs_pins_s pins,
   input wire logic [frs_pkg::DW-1:0] freq_a,
   input wire logic [frs_pkg::DW-1:0] freq_b,
   output logic [frs_pkg::DW-1:0] set_frequency,
   output logic [frs_pkg::DW-1:0] ramp_reference
);
   import frs_pkg::*;

   // ***********************************************
   // State
   // ***********************************************
   typedef struct packed {
      logic [DW-1:0] mode;
      logic [DW-1:0] ctrl;
      logic [DW-1:0] up_rate;
      logic [DW-1:0] dn_rate;
      logic [DW-1:0] src_a;
      logic [DW-1:0] src_b;
      logic [DW-1:0] fmax;
      logic [NTERM-1:0][DW-1:0] tfn;
      frs_pins_s s1;
      frs_pins_s s2;
      logic clr_prev;
      logic stop_prev;
      logic [31:0] tick_cnt;
      logic [ADJW-1:0] adj;
      logic [DW-1:0] set_mon;
      logic [DW-1:0] ramp;
      logic [DW-1:0] rdata;
   } frs_state_s;

   frs_state_s s;
   frs_state_s next_s;

   // True when any terminal carrying the given function is active
   function automatic logic term_on(input logic [NTERM-1:0][DW-1:0] fn,
                                    input logic [NTERM-1:0] lvl,
                                    input logic [DW-1:0] code);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < NTERM; i++) begin
         if (lvl[i] && fn[i] == code) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   function automatic logic [DW-1:0] sat(input logic [DW+1:0] v,
                                         input logic [DW-1:0] lim);
      logic [DW+1:0] l;
      l = {2'b00, lim};
      if (v[DW+1]) begin
         return '0;
      end
      if (v > l) begin
         return lim;
      end
      return v[DW-1:0];
   endfunction

   function automatic logic digits_ok(input logic [DW-1:0] w);
      return w[DW-1:12] == '0 && w[ONES_LSB +: 4] <= ONES_MAX
         && w[TENS_LSB +: 4] <= TENS_MAX && w[HUND_LSB +: 4] <= HUND_MAX;
   endfunction

   // ***********************************************
   // Combinational decode
   // ***********************************************
   logic t_up, t_dn, t_clr, t_swap, t_to_a, t_to_b;
   logic clr_edge, stop_edge, tick, gate, running;
   logic [3:0] ones, tens, hund;
   logic [DW-1:0] main_ref, adj_hz;
   logic [DW+1:0] ea, eb, sum;
   logic [ADJW-1:0] adj_lim, adj_up, adj_dn;
   frs_mode_e eff;

   always_comb begin
      t_up = term_on(s.tfn, s.s2.level, FN_UP);
      t_dn = term_on(s.tfn, s.s2.level, FN_DOWN);
      t_clr = term_on(s.tfn, s.s2.level, FN_CLEAR);
      t_swap = term_on(s.tfn, s.s2.level, FN_SWAP_AB);
      t_to_a = term_on(s.tfn, s.s2.level, FN_COMB_TO_A);
      t_to_b = term_on(s.tfn, s.s2.level, FN_COMB_TO_B);
      running = s.s2.running;
      clr_edge = t_clr && !s.clr_prev;
      stop_edge = s.s2.stop_cmd && !s.stop_prev;
      tick = s.tick_cnt == 32'(TICK_LEN - 1);
      ones = s.ctrl[ONES_LSB +: 4];
      tens = s.ctrl[TENS_LSB +: 4];
      hund = s.ctrl[HUND_LSB +: 4];
      // Channel choice after terminal overrides
      eff = frs_mode_e'(s.mode[2:0]);
      case (frs_mode_e'(s.mode[2:0]))
         FRS_SRC_A: begin
            if (t_swap) begin
               eff = FRS_SRC_B; // see (RL5)
            end
         end
         FRS_SRC_B: begin
            if (t_swap) begin
               eff = FRS_SRC_A; // see (RL5)
            end
         end
         default: begin
            // Channel A wins when both overrides are held
            if (t_to_a) begin
               eff = FRS_SRC_A; // see (RL6)
            end else if (t_to_b) begin
               eff = FRS_SRC_B; // see (RL7)
            end
         end
      endcase
      ea = {2'b00, freq_a};
      eb = {2'b00, freq_b};
      case (eff) // see (RL1)
         FRS_SRC_A: sum = ea;
         FRS_SRC_B: sum = eb;
         FRS_SRC_SUM: sum = ea + eb;
         FRS_SRC_DIFF: sum = ea - eb;
         FRS_SRC_MAX: sum = (ea > eb) ? ea : eb;
         FRS_SRC_MIN: sum = (ea < eb) ? ea : eb;
         default: sum = ea;
      endcase
      main_ref = sat(sum, s.fmax);
      // Enable gating of the up/down terminals
      gate = ones == 4'h0; // see (RL8)
      case (tens)
         4'h0: begin
            if (s.src_a != SRC_KEYPAD && s.src_b != SRC_KEYPAD) begin
               gate = 1'b0; // see (RL9)
            end
         end
         4'h1: gate = gate; // see (RL10)
         4'h2: begin
            if (s.s2.multistep_priority) begin
               gate = 1'b0; // see (RL11)
            end
         end
         default: gate = 1'b0;
      endcase
      if (hund != 4'h0 && !running) begin
         gate = 1'b0; // see (RL13) (RL14)
      end
      adj_lim = ADJW'(s.fmax) * ADJ_SCALE;
      adj_up = s.adj + ADJW'(s.up_rate);
      adj_dn = s.adj - ADJW'(s.dn_rate);
      adj_hz = DW'(s.adj / ADJ_SCALE);
   end

   // ***********************************************
   // Next state
   // ***********************************************
   always_comb begin
      next_s = s;
      next_s.s1 = pins;
      next_s.s2 = s.s1;
      next_s.clr_prev = t_clr;
      next_s.stop_prev = s.s2.stop_cmd;
      next_s.tick_cnt = tick ? '0 : s.tick_cnt + 32'h1;
      // Register writes; illegal values are dropped
      if (req.wr) begin
         case (req.addr)
            ADDR_COMBINE_MODE: begin
               if (req.wdata <= MODE_MAX) begin
                  next_s.mode = req.wdata;
               end
            end
            ADDR_UPDOWN_CONTROL_WORD: begin
               if (req.wdata <= CTRL_MAX && digits_ok(req.wdata)) begin
                  next_s.ctrl = req.wdata; // see (RL8)
               end
            end
            ADDR_UP_RATE: begin
               if (req.wdata >= RATE_MIN && req.wdata <= RATE_MAX) begin
                  next_s.up_rate = req.wdata; // see (RL15)
               end
            end
            ADDR_DOWN_RATE: begin
               if (req.wdata >= RATE_MIN && req.wdata <= RATE_MAX) begin
                  next_s.dn_rate = req.wdata; // see (RL15)
               end
            end
            ADDR_CHANNEL_A_SOURCE_SELECT: next_s.src_a = req.wdata;
            ADDR_CHANNEL_B_SOURCE_SELECT: next_s.src_b = req.wdata;
            ADDR_MAX_OUTPUT_FREQUENCY: begin
               if (req.wdata <= MAX_FREQ_LIMIT) begin
                  next_s.fmax = req.wdata;
               end
            end
            default: begin
               for (int i = 0; i < NTERM; i++) begin
                  if (req.addr == ADDR_TERMINAL_FUNCTION_0 + AW'(i)) begin
                     next_s.tfn[i] = req.wdata;
                  end
               end
            end
         endcase
      end
      // Adjustment: stepped once per tick by the programmed rate
      if (tick && gate) begin
         if (t_up && !t_dn) begin
            next_s.adj = (adj_up > adj_lim) ? adj_lim : adj_up; // see (RL2)
         end else if (t_dn && !t_up) begin
            next_s.adj = (s.adj < ADJW'(s.dn_rate)) ? '0 : adj_dn; // see (RL3)
         end
      end
      if (s.adj > adj_lim) begin
         next_s.adj = adj_lim; // see (RL16)
      end
      // Clears take precedence over a step in the same cycle
      if (clr_edge) begin
         next_s.adj = '0; // see (RL4)
      end
      if (hund == 4'h1 && !running) begin
         next_s.adj = '0; // see (RL13)
      end
      if (hund == 4'h2 && stop_edge) begin
         next_s.adj = '0; // see (RL14)
      end
      // hund == 0 leaves the value untouched at stop; see (RL12)
      next_s.set_mon = sat({2'b00, main_ref} + {2'b00, adj_hz}, // see (RL17)
                           s.fmax); // see (RL18)
      // Ramp follows the set value while running, decays to zero at stop
      begin
         logic [DW-1:0] tgt;
         tgt = running ? s.set_mon : '0;
         if (tick) begin
            if (s.ramp + RAMP_STEP < tgt) begin
               next_s.ramp = s.ramp + RAMP_STEP;
            end else if (s.ramp > tgt + RAMP_STEP) begin
               next_s.ramp = s.ramp - RAMP_STEP;
            end else begin
               next_s.ramp = tgt;
            end
         end
      end
      // Read data valid only in the cycle after the strobe
      next_s.rdata = '0;
      if (req.rd) begin
         case (req.addr)
            ADDR_COMBINE_MODE: next_s.rdata = s.mode;
            ADDR_UPDOWN_CONTROL_WORD: next_s.rdata = s.ctrl;
            ADDR_UP_RATE: next_s.rdata = s.up_rate;
            ADDR_DOWN_RATE: next_s.rdata = s.dn_rate;
            ADDR_SET_FREQUENCY_MONITOR: next_s.rdata = s.set_mon; // see (RL16)
            ADDR_RAMP_REFERENCE_MONITOR: next_s.rdata = s.ramp;
            ADDR_ADJUSTMENT_VALUE_MONITOR: next_s.rdata = adj_hz;
            ADDR_CHANNEL_A_SOURCE_SELECT: next_s.rdata = s.src_a;
            ADDR_CHANNEL_B_SOURCE_SELECT: next_s.rdata = s.src_b;
            ADDR_MAX_OUTPUT_FREQUENCY: next_s.rdata = s.fmax;
            default: begin
               for (int i = 0; i < NTERM; i++) begin
                  if (req.addr == ADDR_TERMINAL_FUNCTION_0 + AW'(i)) begin
                     next_s.rdata = s.tfn[i];
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         s <= '0; // see (RL16)
         s.mode <= RST_COMBINE_MODE;
         s.ctrl <= RST_UPDOWN_CONTROL_WORD;
         s.up_rate <= RST_RATE; // see (RL15)
         s.dn_rate <= RST_RATE;
         s.src_a <= RST_SOURCE_A;
         s.src_b <= RST_SOURCE_B;
         s.fmax <= RST_MAX_FREQ;
         s.tfn <= {NTERM{RST_TERM_FUNC}};
      end else begin
         s <= next_s;
      end
   end

   assign rdata = s.rdata;
   assign set_frequency = s.set_mon;
   assign ramp_reference = s.ramp;

   // ***********************************************
   // Assertions
   // ***********************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   property p_mode_a;
      s.mode == RST_COMBINE_MODE && !t_swap && s.adj == '0
         |=> s.set_mon == sat({2'b00, $past(freq_a)}, $past(s.fmax));
   endproperty
   a_mode_a: assert property (p_mode_a) // see (RL1)
      else $error("mode A mismatch");

   property p_swap;
      s.mode == RST_COMBINE_MODE && t_swap && s.adj == '0
         |=> s.set_mon == sat({2'b00, $past(freq_b)}, $past(s.fmax));
   endproperty
   a_swap: assert property (p_swap) // see (RL5)
      else $error("swap to B failed");

   property p_up_step;
      tick && gate && t_up && !t_dn && !clr_edge && adj_up <= adj_lim
         && !(hund == 4'h2 && stop_edge)
         |=> s.adj == $past(s.adj) + ADJW'($past(s.up_rate));
   endproperty
   a_up_step: assert property (p_up_step) // see (RL2)
      else $error("up step wrong");

   property p_dn_step;
      tick && gate && t_dn && !t_up && !clr_edge && s.adj >= ADJW'(s.dn_rate)
         && !(hund == 4'h2 && stop_edge) && s.adj <= adj_lim
         |=> s.adj == $past(s.adj) - ADJW'($past(s.dn_rate));
   endproperty
   a_dn_step: assert property (p_dn_step) // see (RL3)
      else $error("down step wrong");

   property p_clear;
      clr_edge |=> s.adj == '0;
   endproperty
   a_clear: assert property (p_clear) // see (RL4)
      else $error("clear ignored");

   property p_ignored;
      ones == ONES_MAX && hund == 4'h0 && !clr_edge && s.adj <= adj_lim
         |=> $stable(s.adj);
   endproperty
   a_ignored: assert property (p_ignored) // see (RL8)
      else $error("adjust not gated");

   property p_tens0;
      tens == 4'h0 && hund == 4'h0 && s.src_a != SRC_KEYPAD
         && s.src_b != SRC_KEYPAD && !clr_edge && s.adj <= adj_lim
         |=> $stable(s.adj);
   endproperty
   a_tens0: assert property (p_tens0) // see (RL9)
      else $error("source gate broken");

   property p_stopped;
      hund == 4'h1 && !running |=> s.adj == '0;
   endproperty
   a_stopped: assert property (p_stopped) // see (RL13)
      else $error("not cleared stopped");

   property p_stop_cmd;
      hund == 4'h2 && stop_edge |=> s.adj == '0;
   endproperty
   a_stop_cmd: assert property (p_stop_cmd) // see (RL14)
      else $error("stop cmd no clear");

   property p_range;
      s.set_mon <= s.fmax || $changed(s.fmax);
   endproperty
   a_range: assert property (p_range) // see (RL16)
      else $error("set value over max");

endmodule // frs_top

`default_nettype wire

// ---- tb/frs_term_model.sv ----
// Purpose: Terminal, run and stop source facing the reference selector.
// Assumes: Levels change just after a rising edge of clk_sys.
// Notes:   Pulses last three cycles so the two-flop sync always sees them.
`timescale 1ns/100ps
`default_nettype none

module frs_term_model
   import frs_pkg::*;
(
   input wire logic clk_sys,
   output var frs_pkg::frs_pins_s pins
);
   initial pins = '0;

   // ***********************************************
   // Pin drivers
   // ***********************************************
   task automatic set_level(input int idx, input logic val);
      @(posedge clk_sys);
      pins.level[idx] <= val;
   endtask

   task automatic set_run(input logic run, input logic prio);
      @(posedge clk_sys);
      pins.running <= run;
      pins.multistep_priority <= prio;
   endtask

   task automatic pulse(input int idx, input logic is_stop);
      @(posedge clk_sys);
      if (is_stop) pins.stop_cmd <= 1'b1;
      else pins.level[idx] <= 1'b1;
      repeat (3) @(posedge clk_sys);
      if (is_stop) pins.stop_cmd <= 1'b0;
      else pins.level[idx] <= 1'b0;
   endtask
endmodule // frs_term_model

`default_nettype wire

// ---- tb/frs_top_tb_top.sv ----
// Purpose: Self-checking bench of the reference selector.
// Assumes: Tick shortened to 20 cycles; 50 Hz/s rate gives 50 per tick.
// Notes:   Tick phase is free, so adjustment counts are checked in a band.
`timescale 1ns/100ps
`default_nettype none

module frs_top_tb_top;
   import frs_pkg::*;
   localparam int unsigned TL = 20;
   logic clk_sys;
   logic resetn;
   frs_req_s req;
   logic [DW-1:0] rdata;
   logic [DW-1:0] set_frequency;
   logic [DW-1:0] ramp_reference;
   logic [DW-1:0] freq_a;
   logic [DW-1:0] freq_b;
   logic [DW-1:0] v;
   logic [DW-1:0] exp_m [6];
   frs_pins_s pins;
   int n_mismatch;
   int tests_run;

   frs_top #(.TICK_LEN(TL)) u_dut (.clk_sys(clk_sys), .resetn(resetn),
      .req(req), .rdata(rdata), .pins(pins), .freq_a(freq_a),
      .freq_b(freq_b), .set_frequency(set_frequency),
      .ramp_reference(ramp_reference));
   frs_term_model u_term (.clk_sys(clk_sys), .pins(pins));

   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end

   // ***********************************************
   // Access and check tasks
   // ***********************************************
   task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge clk_sys);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge clk_sys);
      req.wr <= 1'b0;
   endtask

   task automatic rd(input logic [AW-1:0] a, output logic [DW-1:0] d);
      @(posedge clk_sys);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge clk_sys);
      req.rd <= 1'b0;
      #1 d = rdata;
   endtask

   task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] exp);
      logic [DW-1:0] d;
      rd(a, d);
      chk(d, exp);
   endtask

   // Adjustment monitor must fall in lo..hi
   task automatic adj_band(input logic [DW-1:0] lo, input logic [DW-1:0] hi);
      rd(ADDR_ADJUSTMENT_VALUE_MONITOR, v);
      chk({15'h0000, (v >= lo && v <= hi)}, 16'h0001);
   endtask

   task automatic settle();
      repeat (5) @(posedge clk_sys);
   endtask

   // Hold one terminal for n ticks, then let the sync drain
   task automatic hold(input int idx, input int n);
      u_term.set_level(idx, 1'b1);
      repeat (n * TL) @(posedge clk_sys);
      u_term.set_level(idx, 1'b0);
      settle();
   endtask

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      repeat (100000) @(posedge clk_sys);
      n_mismatch++;
      end_of_test();
   end

   // ***********************************************
   // Main sequence
   // ***********************************************
   initial begin
      resetn = 1'b0;
      req = '0;
      freq_a = 16'h0bb8;
      freq_b = 16'h03e8;
      n_mismatch = 0;
      tests_run = 0;
      exp_m = '{16'h0bb8, 16'h03e8, 16'h0fa0, 16'h07d0, 16'h0bb8, 16'h03e8};
      repeat (5) @(posedge clk_sys);
      #1 chk(set_frequency, 16'h0000);
      chk(ramp_reference, 16'h0000);
      repeat (5) @(posedge clk_sys);
      resetn <= 1'b1;
      rchk(ADDR_UP_RATE, 16'h0032);
      rchk(ADDR_DOWN_RATE, 16'h0032);
      rchk(ADDR_UPDOWN_CONTROL_WORD, 16'h0000);
      rchk(ADDR_COMBINE_MODE, 16'h0000);
      rchk(ADDR_RAMP_REFERENCE_MONITOR, 16'h0000);
      rchk(ADDR_ADJUSTMENT_VALUE_MONITOR, 16'h0000);
      rchk(5'h1f, 16'h0000);
      for (int i = 0; i < 6; i++) begin
         wr(ADDR_COMBINE_MODE, 16'(i));
         settle();
         chk(set_frequency, exp_m[i]);
         rchk(ADDR_SET_FREQUENCY_MONITOR, exp_m[i]);
      end
      wr(ADDR_COMBINE_MODE, 16'h0006);
      rchk(ADDR_COMBINE_MODE, 16'h0005);
      // Swap terminal is dead in combined modes, live in single ones
      wr(ADDR_COMBINE_MODE, 16'h0002);
      wr(ADDR_TERMINAL_FUNCTION_0, FN_SWAP_AB);
      wr(ADDR_TERMINAL_FUNCTION_0 + 5'h01, FN_COMB_TO_A);
      wr(ADDR_TERMINAL_FUNCTION_0 + 5'h02, FN_COMB_TO_B);
      u_term.set_level(0, 1'b1);
      settle();
      chk(set_frequency, 16'h0fa0);
      wr(ADDR_COMBINE_MODE, 16'h0000);
      settle();
      chk(set_frequency, 16'h03e8);
      u_term.set_level(0, 1'b0);
      wr(ADDR_COMBINE_MODE, 16'h0002);
      u_term.set_level(1, 1'b1);
      settle();
      chk(set_frequency, 16'h0bb8);
      u_term.set_level(1, 1'b0);
      u_term.set_level(2, 1'b1);
      settle();
      chk(set_frequency, 16'h03e8);
      u_term.set_level(2, 1'b0);
      wr(ADDR_COMBINE_MODE, 16'h0000);
      // Up/down adjustment at 50 per tick
      wr(ADDR_UP_RATE, 16'h1388);
      wr(ADDR_DOWN_RATE, 16'h1388);
      wr(ADDR_UP_RATE, 16'h1389);
      rchk(ADDR_UP_RATE, 16'h1388);
      wr(ADDR_TERMINAL_FUNCTION_0 + 5'h03, FN_UP);
      wr(ADDR_TERMINAL_FUNCTION_0 + 5'h04, FN_DOWN);
      wr(ADDR_TERMINAL_FUNCTION_0 + 5'h05, FN_CLEAR);
      hold(3, 10);
      adj_band(16'h01c2, 16'h0226);
      chk(set_frequency, 16'h0bb8 + v);
      hold(4, 4);
      adj_band(16'h00fa, 16'h0190);
      u_term.pulse(5, 1'b0);
      settle();
      rchk(ADDR_ADJUSTMENT_VALUE_MONITOR, 16'h0000);
      wr(ADDR_UPDOWN_CONTROL_WORD, 16'h0001);
      hold(3, 5);
      rchk(ADDR_ADJUSTMENT_VALUE_MONITOR, 16'h0000);
      wr(ADDR_UPDOWN_CONTROL_WORD, 16'h0000);
      wr(ADDR_CHANNEL_A_SOURCE_SELECT, 16'h0001);
      wr(ADDR_CHANNEL_B_SOURCE_SELECT, 16'h0001);
      hold(3, 5);
      rchk(ADDR_ADJUSTMENT_VALUE_MONITOR, 16'h0000);
      wr(ADDR_UPDOWN_CONTROL_WORD, 16'h0010);
      hold(3, 5);
      adj_band(16'h00c8, 16'h012c);
      // Near the top the sum must clip at the maximum
      freq_a <= 16'h1342;
      settle();
      chk(set_frequency, 16'h1388);
      freq_a <= 16'h0bb8;
      // A real run and stop must leave a hundreds-zero adjustment alone
      u_term.set_run(1'b1, 1'b0);
      u_term.pulse(0, 1'b1);
      u_term.set_run(1'b0, 1'b0);
      repeat (5 * TL) @(posedge clk_sys);
      adj_band(16'h00c8, 16'h012c);
      u_term.pulse(5, 1'b0);
      wr(ADDR_UPDOWN_CONTROL_WORD, 16'h0020);
      u_term.set_run(1'b0, 1'b1);
      hold(3, 5);
      rchk(ADDR_ADJUSTMENT_VALUE_MONITOR, 16'h0000);
      u_term.set_run(1'b0, 1'b0);
      hold(3, 5);
      adj_band(16'h00c8, 16'h012c);
      u_term.pulse(5, 1'b0);
      wr(ADDR_UPDOWN_CONTROL_WORD, 16'h0110);
      u_term.set_run(1'b1, 1'b0);
      hold(3, 5);
      adj_band(16'h00c8, 16'h012c);
      repeat (60 * TL) @(posedge clk_sys);
      chk(ramp_reference, 16'h0bb8 + v);
      chk(set_frequency, 16'h0bb8 + v);
      u_term.set_run(1'b0, 1'b0);
      settle();
      rchk(ADDR_ADJUSTMENT_VALUE_MONITOR, 16'h0000);
      // Stopped: ramp must walk back down to zero
      repeat (40 * TL) @(posedge clk_sys);
      rchk(ADDR_RAMP_REFERENCE_MONITOR, 16'h0000);
      wr(ADDR_UPDOWN_CONTROL_WORD, 16'h0210);
      u_term.set_run(1'b1, 1'b0);
      hold(3, 5);
      adj_band(16'h00c8, 16'h012c);
      u_term.pulse(0, 1'b1);
      settle();
      rchk(ADDR_ADJUSTMENT_VALUE_MONITOR, 16'h0000);
      wr(ADDR_UPDOWN_CONTROL_WORD, 16'h0222);
      rchk(ADDR_UPDOWN_CONTROL_WORD, 16'h0210);
      wr(ADDR_DOWN_RATE, 16'h0001);
      rchk(ADDR_DOWN_RATE, 16'h0001);
      end_of_test();
   end
endmodule // frs_top_tb_top

`default_nettype wire
